// file: hw/icr_pkg.sv
// constants for the interrupt controller with reset status flags
// assumes a 32-bit classic wishbone register bus and one system clock
// Overview of operation
// - four sources: external pin, timer zero, port b change, comparator.
// - global enable, bit 7 of control register, gates every interrupt.
// - every reset clears the global enable.
// - return-from-interrupt instruction sets the global enable again.
// - pin, port b and timer flags sit in the control register.
// - peripheral flag and enable sit in their own two registers.
// - each source has its own enable bit.
// - taking an interrupt clears global enable, pushes return, vectors 0004h.
// - external event to vector takes three or four instruction cycles.
// - latency does not depend on one- or two-cycle instructions.
// - flags set on their events whatever the enable bits say.
// - clearing global enable suppresses an interrupt due next cycle.
// - core executes a no-operation right after global enable is cleared.
// - suppressed interrupts stay pending until global enable returns.
// - power-on reset clears power-on flag, sets timeout and powerdown.
// - power-on flag is bit 1 of power status, kept by other resets.
package icr_pkg;
  typedef logic [31:0] icr_word_t;
  // register byte offsets
  localparam logic [7:0] OFS_IRQ_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_PERIPH_FLAG  = 8'h04;
  localparam logic [7:0] OFS_PERIPH_EN    = 8'h08;
  localparam logic [7:0] OFS_POWER_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CORE_STATUS  = 8'h10;
  localparam logic [7:0] OFS_EVT_STATUS   = 8'h14;
  localparam logic [7:0] OFS_EVT_MASK     = 8'h18;
  // control register fields
  localparam int BIT_GIE      = 7;
  localparam int BIT_PEIE     = 6;
  localparam int BIT_T0_EN    = 5;
  localparam int BIT_EXT_EN   = 4;
  localparam int BIT_RB_EN    = 3;
  localparam int BIT_T0_FLAG  = 2;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_RB_FLAG  = 0;
  // peripheral registers: comparator bit
  localparam int BIT_CMP      = 6;
  // power status fields
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_BROWNOUT = 0;
  // core status fields
  localparam int BIT_TIMEOUT   = 4;
  localparam int BIT_POWERDOWN = 3;
  // event status bits: vector taken, return, suppressed
  localparam int EVT_W        = 3;
  localparam int EVT_TAKEN    = 0;
  localparam int EVT_RETURN   = 1;
  localparam int EVT_SUPPRESS = 2;
  // reset values
  localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPH      = 8'h00;
  localparam logic [EVT_W-1:0] RST_EVT   = 3'h0;
  // vector and instruction cycle timing
  localparam int          PC_W        = 13;
  localparam logic [12:0] IRQ_VECTOR  = 13'h0004;
  localparam int          CLK_PER_CYC = 4;
  localparam int          DIV_W       = 2;
  // synchronised pins: ext pin, four port b pins, comparator output
  localparam int          SYNC_W      = 6;
endpackage

// file: hw/icr_cycle_div.sv
// divider giving one enable pulse per instruction cycle
// assumes the system clock is four times the instruction rate
`timescale 1ns/1ps
module icr_cycle_div
  import icr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      cyc_en
);
  logic [DIV_W-1:0] cnt;
  logic             wrap;

  // wrap at the last clock of each instruction cycle
  assign wrap   = (cnt == DIV_W'(CLK_PER_CYC - 1));
  assign cyc_en = wrap;

  // free-running counter, restarted by reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= wrap ? '0 : cnt + DIV_W'(1);
    end
  end
endmodule

// file: hw/icr_sync_edge.sv
// two-stage pin synchroniser with a change detector behind it
// assumes inputs are asynchronous pins; outputs are a clean sys-clock level and one-clock rise and change pulses
`timescale 1ns/1ps
module icr_sync_edge
  import icr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [SYNC_W-1:0] pin,
  output logic      [SYNC_W-1:0] level,
  output logic      [SYNC_W-1:0] rise,
  output logic      [SYNC_W-1:0] change
);
  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      logic meta;
      logic stab;
      logic prev;
      // first stage feeds only the second one
      // stages are not reset: they flush while reset is held, so at
      // release the history matches the pin's resting level, high or low
      always_ff @(posedge clk) begin
        meta <= pin[i];
        stab <= meta;
        prev <= stab;
      end
      assign level[i]  = stab;
      // nothing is reported while reset is held
      assign rise[i]   = rst_n & stab & ~prev;
      assign change[i] = rst_n & (stab ^ prev);
    end
  endgenerate
endmodule

// file: hw/icr_top.sv
// interrupt controller with power/reset status flags, wishbone slave
// assumes the core decodes instructions and reports return and
// global-enable-clear instructions as one-clock strobes on SYS_CLK
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module icr_top
  import icr_pkg::*;
(
  input  wire logic           SYS_CLK,
  input  wire logic           RST_N,
  // reset cause and power events from the same clock domain
  input  wire logic           POWER_ON_RESET,
  input  wire logic           BROWNOUT_EVT,
  input  wire logic           WDT_TIMEOUT_EVT,
  input  wire logic           SLEEP_ENTER_EVT,
  // interrupt sources
  input  wire logic           EXT_IRQ_PIN,
  input  wire logic [3:0]     PORTB_UPPER_PINS,
  input  wire logic           CMP_OUT_PIN,
  input  wire logic           TIMER_ZERO_OVF,
  // core handshake
  input  wire logic           RETURN_FROM_IRQ_INSTR,
  input  wire logic           CORE_GIE_CLEAR,
  output logic                VECTOR_LOAD,
  output logic                PUSH_RETURN,
  output logic [PC_W-1:0]     VECTOR_ADDR,
  output logic                FORCE_NOP,
  output logic                CORE_IRQ_REQ,
  // classic wishbone slave
  input  wire logic           WB_CYC_I,
  input  wire logic           WB_STB_I,
  input  wire logic           WB_WE_I,
  input  wire logic [7:0]     WB_ADR_I,
  input  wire logic [3:0]     WB_SEL_I,
  input  wire icr_pkg::icr_word_t WB_DAT_I,
  output icr_pkg::icr_word_t  WB_DAT_O,
  output logic                WB_ACK_O,
  // system interrupt line
  output logic                IRQ
);
  import icr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // instruction cycle enable and pin synchronisers

  logic              cyc_en;
  logic [SYNC_W-1:0] pin_level;
  logic [SYNC_W-1:0] pin_rise;
  logic [SYNC_W-1:0] pin_change;

  icr_cycle_div u_div (
    .clk    (SYS_CLK),
    .rst_n  (RST_N),
    .cyc_en (cyc_en)
  );

  icr_sync_edge u_sync (
    .clk    (SYS_CLK),
    .rst_n  (RST_N),
    .pin    ({CMP_OUT_PIN, PORTB_UPPER_PINS, EXT_IRQ_PIN}),
    .level  (pin_level),
    .rise   (pin_rise),
    .change (pin_change)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [7:0]     irq_control;
  logic [7:0]     periph_flag;
  logic [7:0]     periph_en;
  logic           power_on_flag;
  logic           brownout_flag;
  logic           timeout_flag;
  logic           powerdown_flag;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  icr_word_t      rd_mux;

  wire bus_req   = WB_CYC_I & WB_STB_I;
  // a write lands on the edge at which the master sees ack high, so the
  // register and the answer it was given change together
  wire bus_wr    = bus_req & WB_WE_I & WB_ACK_O;
  wire lane0     = WB_SEL_I[0];
  wire wr_ctrl   = bus_wr & lane0 & (WB_ADR_I == OFS_IRQ_CONTROL);
  wire wr_pflag  = bus_wr & lane0 & (WB_ADR_I == OFS_PERIPH_FLAG);
  wire wr_pen    = bus_wr & lane0 & (WB_ADR_I == OFS_PERIPH_EN);
  wire wr_power  = bus_wr & lane0 & (WB_ADR_I == OFS_POWER_STATUS);
  wire wr_evt    = bus_wr & lane0 & (WB_ADR_I == OFS_EVT_STATUS);
  wire wr_mask   = bus_wr & lane0 & (WB_ADR_I == OFS_EVT_MASK);
  wire [7:0] wd  = WB_DAT_I[7:0];

  // read mux; unmapped offsets read as zero but still acknowledge
  always_comb begin
    rd_mux = '0;
    unique case (WB_ADR_I)
      OFS_IRQ_CONTROL:  rd_mux[7:0] = irq_control;
      OFS_PERIPH_FLAG:  rd_mux[7:0] = periph_flag;
      OFS_PERIPH_EN:    rd_mux[7:0] = periph_en;
      OFS_POWER_STATUS: begin
        rd_mux[BIT_POWER_ON] = power_on_flag;
        rd_mux[BIT_BROWNOUT] = brownout_flag;
      end
      OFS_CORE_STATUS:  begin
        rd_mux[BIT_TIMEOUT]   = timeout_flag;
        rd_mux[BIT_POWERDOWN] = powerdown_flag;
      end
      OFS_EVT_STATUS:   rd_mux[EVT_W-1:0] = evt_status;
      OFS_EVT_MASK:     rd_mux[EVT_W-1:0] = evt_mask;
      default:          rd_mux = '0;
    endcase
  end

  // one wait state: ack the clock after the request, drop it next
  // read word is latched every clock; only the one beside ack counts
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= bus_req & ~WB_ACK_O;
      WB_DAT_O <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source events

  // flags set regardless of enables
  // the pin fires on its rising edge, port b and comparator on either
  wire ext_evt = pin_rise[0];
  wire rb_evt  = |pin_change[4:1];
  wire cmp_evt = pin_change[5];
  wire t0_evt  = TIMER_ZERO_OVF;

  ////////////////////////////////////////////////////////////////////////
  // global enable: take, return and software writes

  logic take;
  logic gie_clr_evt;
  logic next_gie;

  // a bus write that drops the enable counts like the core's own clear
  // detect enable clear
  assign gie_clr_evt = CORE_GIE_CLEAR |
                       (wr_ctrl & irq_control[BIT_GIE] & ~wd[BIT_GIE]);

  always_comb begin
    next_gie = irq_control[BIT_GIE];
    if (wr_ctrl)
      next_gie = wd[BIT_GIE];
    if (CORE_GIE_CLEAR)
      next_gie = 1'b0;
    if (RETURN_FROM_IRQ_INSTR)
      next_gie = 1'b1;
    if (take)
      next_gie = 1'b0;    // entry beats a late return strobe
  end

  ////////////////////////////////////////////////////////////////////////
  // control register: enables written by software, flags set-wins

  logic [7:0] next_ctrl;
  logic [7:0] next_pflag;

  // an event in the same clock as a software clear wins
  // flags beside enables
  always_comb begin
    next_ctrl = irq_control;
    if (wr_ctrl)
      next_ctrl = wd;
    next_ctrl[BIT_GIE]      = next_gie;
    next_ctrl[BIT_T0_FLAG]  = next_ctrl[BIT_T0_FLAG]  | t0_evt;
    next_ctrl[BIT_EXT_FLAG] = next_ctrl[BIT_EXT_FLAG] | ext_evt;
    next_ctrl[BIT_RB_FLAG]  = next_ctrl[BIT_RB_FLAG]  | rb_evt;
  end

  always_comb begin
    next_pflag = periph_flag;
    if (wr_pflag)
      next_pflag = wd;
    next_pflag[BIT_CMP] = next_pflag[BIT_CMP] | cmp_evt;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      irq_control <= RST_IRQ_CONTROL;
      periph_flag <= RST_PERIPH;
      periph_en   <= RST_PERIPH;
    end else begin
      irq_control <= next_ctrl;
      periph_flag <= next_pflag;
      if (wr_pen)
        periph_en <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request combination

  logic periph_req;
  logic src_req;
  logic irq_req;

  assign periph_req = irq_control[BIT_PEIE] &
                      (periph_flag[BIT_CMP] & periph_en[BIT_CMP]);
  assign src_req = (irq_control[BIT_T0_FLAG]  & irq_control[BIT_T0_EN])  |
                   (irq_control[BIT_EXT_FLAG] & irq_control[BIT_EXT_EN]) |
                   (irq_control[BIT_RB_FLAG]  & irq_control[BIT_RB_EN])  |
                   periph_req;
  assign irq_req = src_req & irq_control[BIT_GIE];
  assign CORE_IRQ_REQ = irq_req;

  ////////////////////////////////////////////////////////////////////////
  // entry pipeline, counted in instruction cycles only

  // stage1 and stage2 hold a request seen on earlier cycle enables
  logic stage1;
  logic stage2;
  logic nop_hold;

  assign take = cyc_en & stage2 & irq_req & ~nop_hold;

  // the flush wins over the enable, so a clear that meets a stage
  // advance in one clock cannot leave that stage set
  // squash pending entry
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else if (gie_clr_evt | take) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else if (cyc_en) begin
      stage1 <= irq_req & ~nop_hold;
      stage2 <= stage1 & irq_req & ~nop_hold;
    end
  end

  // no-operation after clear
  // held until the end of the following instruction cycle
  logic nop_arm;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      nop_arm  <= 1'b0;
      nop_hold <= 1'b0;
    end else if (gie_clr_evt) begin
      nop_arm  <= 1'b1;
      nop_hold <= 1'b0;
    end else if (cyc_en) begin
      nop_hold <= nop_arm;
      nop_arm  <= 1'b0;
    end
  end
  assign FORCE_NOP = nop_hold;

  // the vector is constant; loading it every clock keeps it valid
  // push and vector
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      VECTOR_LOAD <= 1'b0;
      PUSH_RETURN <= 1'b0;
      VECTOR_ADDR <= '0;
    end else begin
      VECTOR_LOAD <= take;
      PUSH_RETURN <= take;
      VECTOR_ADDR <= IRQ_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power and reset status flags

  // power-on flag kept otherwise
  // the cause input is sampled by the clock while reset is held
  // a reset without the power-on cause leaves all three flags alone, so
  // software can tell a power-up from any later reset
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      if (POWER_ON_RESET) begin
        power_on_flag  <= 1'b0;
        timeout_flag   <= 1'b1;
        powerdown_flag <= 1'b1;
      end
    end else begin
      if (wr_power)
        power_on_flag <= wd[BIT_POWER_ON];
      if (WDT_TIMEOUT_EVT)
        timeout_flag <= 1'b0;
      if (SLEEP_ENTER_EVT)
        powerdown_flag <= 1'b0;
    end
  end

  // brownout flag: software sets it, a brownout clears it
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      if (BROWNOUT_EVT)
        brownout_flag <= 1'b0;
    end else if (BROWNOUT_EVT) begin
      brownout_flag <= 1'b0;
    end else if (wr_power) begin
      brownout_flag <= wd[BIT_BROWNOUT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system interrupt: sticky events, write-one-to-clear, mask

  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] next_evt;

  assign evt_set[EVT_TAKEN]    = take;
  assign evt_set[EVT_RETURN]   = RETURN_FROM_IRQ_INSTR;
  assign evt_set[EVT_SUPPRESS] = gie_clr_evt & (stage1 | stage2);
  // a new event beats the clear in the same clock
  assign next_evt = (evt_status & ~(wr_evt ? wd[EVT_W-1:0] : '0)) |
                    evt_set;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      evt_status <= RST_EVT;
      evt_mask   <= RST_EVT;
    end else begin
      evt_status <= next_evt;
      if (wr_mask)
        evt_mask <= wd[EVT_W-1:0];
    end
  end

  // level output: high until software clears or masks the event
  assign IRQ = |(evt_status & evt_mask);

endmodule

// file: verif/icr_assertions.sv
// checker on the top ports of the interrupt controller
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
module icr_checker
  import icr_pkg::*;
(
  input wire logic            SYS_CLK,
  input wire logic            RST_N,
  input wire logic            CORE_GIE_CLEAR,
  input wire logic            VECTOR_LOAD,
  input wire logic            PUSH_RETURN,
  input wire logic [PC_W-1:0] VECTOR_ADDR,
  input wire logic            FORCE_NOP,
  input wire logic            CORE_IRQ_REQ,
  input wire logic            WB_CYC_I,
  input wire logic            WB_STB_I,
  input wire logic            WB_ACK_O,
  input wire logic            IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  //////////////////////////////
  a_push_with_vec:
    assert property (VECTOR_LOAD |-> PUSH_RETURN) else $error("no push");
  a_vector_value:
    assert property (VECTOR_LOAD |-> VECTOR_ADDR == IRQ_VECTOR)
      else $error("bad vector");
  a_take_drops_req:
    assert property (VECTOR_LOAD |-> !CORE_IRQ_REQ) else $error("gie kept");
  a_take_needs_req:
    assert property ($rose(VECTOR_LOAD) |-> $past(CORE_IRQ_REQ))
      else $error("take without request");
  // reset itself is the cause here, so it cannot disable the check
  a_reset_quiet:
    assert property (disable iff (1'b0) !RST_N |=> !VECTOR_LOAD
      && !CORE_IRQ_REQ) else $error("active after reset");
  a_nop_length:
    assert property ($rose(FORCE_NOP) |-> FORCE_NOP[*4] ##1 !FORCE_NOP)
      else $error("nop not one cycle");
  a_clear_gives_nop:
    assert property (CORE_GIE_CLEAR |-> ##[1:5] FORCE_NOP)
      else $error("no nop after clear");
  a_nop_blocks_take:
    assert property (FORCE_NOP |-> !VECTOR_LOAD) else $error("take in nop");
  a_ack_one_wait:
    assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("late ack");
  c_take: cover property (VECTOR_LOAD);
  c_nop: cover property ($rose(FORCE_NOP));
  c_irq: cover property ($rose(IRQ));
endmodule
bind icr_top icr_checker u_icr_checker (.*);

// file: verif/icr_core_model.sv
// core model: program counter and return stack
// assumes vector and push pulses on the controller clock
`timescale 1ns/1ps
module icr_core_model
  import icr_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            vector_load,
  input  wire logic            push_return,
  input  wire logic [PC_W-1:0] vector_addr,
  input  wire logic            do_ret,
  output logic                 ret_strobe,
  output logic      [PC_W-1:0] pc,
  output int                   takes
);
  logic [PC_W-1:0] stack [$];
  //////////////////////////////
  // pc steps every clock; a short cut, the core needs no fetch model
  always @(posedge clk) begin
    ret_strobe <= do_ret;
    if (vector_load && push_return) begin
      stack.push_back(pc);
      pc <= vector_addr;
      takes <= takes + 1;
    end
    else if (ret_strobe && stack.size() > 0) begin
      pc <= stack.pop_back();
    end
    else begin
      pc <= pc + 13'h1;
    end
  end
  initial begin
    pc = '0;
    takes = 0;
    ret_strobe = 1'b0;
  end
endmodule

// file: verif/tb.sv
// bench for the interrupt controller, table rows then hand cases
// assumes icr_top, the core model and the bound checker
`timescale 1ns/1ps
module tb;
  import icr_pkg::*;
  typedef struct {logic [7:0] a; icr_word_t w; icr_word_t r;} icr_row_s;
  logic            clk = 0, rst_n = 0, por = 1, ext = 0, tmr = 0;
  logic            cmp = 0, gclr = 0, do_ret = 0, cyc = 0, stb = 0;
  logic            we = 0, ret, vl, pr, nop, req, ack, irq;
  logic [3:0]      pb = 4'h0;
  logic [7:0]      adr = 8'h00;
  logic [PC_W-1:0] va, pc;
  icr_word_t       wdat = '0, rdat, dat_o;
  int              takes, error_cnt = 0, checked = 0, n, t0;
  icr_row_s rows [8] = '{
    '{8'h00, 32'h78, 32'h78}, '{8'h04, 32'h40, 32'h40},
    '{8'h04, 32'h00, 32'h00}, '{8'h08, 32'h40, 32'h40},
    '{8'h0c, 32'h03, 32'h03}, '{8'h10, 32'h00, 32'h18},
    '{8'h1c, 32'hff, 32'h00}, '{8'h18, 32'h07, 32'h07}};
  always #20 clk = ~clk;
  icr_top u_icr_top (.SYS_CLK(clk), .RST_N(rst_n), .POWER_ON_RESET(por),
    .BROWNOUT_EVT(1'b0), .WDT_TIMEOUT_EVT(1'b0), .SLEEP_ENTER_EVT(1'b0),
    .EXT_IRQ_PIN(ext), .PORTB_UPPER_PINS(pb), .CMP_OUT_PIN(cmp),
    .TIMER_ZERO_OVF(tmr), .RETURN_FROM_IRQ_INSTR(ret),
    .CORE_GIE_CLEAR(gclr), .VECTOR_LOAD(vl), .PUSH_RETURN(pr),
    .VECTOR_ADDR(va), .FORCE_NOP(nop), .CORE_IRQ_REQ(req),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .IRQ(irq));
  icr_core_model u_icr_core_model (.clk(clk), .vector_load(vl),
    .push_return(pr), .vector_addr(va), .do_ret(do_ret),
    .ret_strobe(ret), .pc(pc), .takes(takes));
  //////////////////////////////
  task automatic chk(input icr_word_t g, input icr_word_t e);
    checked++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask
  // holds the request until ack is sampled, then drops it a cycle
  task automatic wb(input logic w, input logic [7:0] a, input icr_word_t d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) error_cnt++;
    rdat = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input icr_word_t e);
    wb(0, a, '0);
    chk(rdat, e);
  endtask
  task automatic wait_hi(ref logic s);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== 1'b1 && n < 40);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    por <= 0;
    rd_chk(OFS_CORE_STATUS, 32'h18);
    wb(0, OFS_POWER_STATUS, '0);
    chk(rdat & 32'h2, 32'h0);
    foreach (rows[i]) begin
      wb(1, rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].r);
    end
    wb(1, OFS_IRQ_CONTROL, 32'h0);
    ext <= 1;
    repeat (8) @(posedge clk);
    rd_chk(OFS_IRQ_CONTROL, 32'h02);
    wb(1, OFS_IRQ_CONTROL, 32'h82);
    repeat (20) @(posedge clk);
    chk(takes, 0);
    wb(1, OFS_IRQ_CONTROL, 32'h12);
    repeat (20) @(posedge clk);
    chk(takes, 0);
    wb(1, OFS_IRQ_CONTROL, 32'h92);
    wait_hi(vl);
    @(posedge clk);
    chk(pc, IRQ_VECTOR);
    rd_chk(OFS_IRQ_CONTROL, 32'h12);
    chk(irq, 1);
    wb(1, OFS_EVT_MASK, 32'h0);
    @(posedge clk);
    chk(irq, 0);
    wb(1, OFS_EVT_STATUS, 32'h7);
    rd_chk(OFS_EVT_STATUS, 32'h0);
    wb(1, OFS_EVT_MASK, 32'h7);
    chk(irq, 0);
    wb(1, OFS_IRQ_CONTROL, 32'h10);
    do_ret <= 1;
    @(posedge clk);
    do_ret <= 0;
    repeat (3) @(posedge clk);
    rd_chk(OFS_IRQ_CONTROL, 32'h90);
    for (int k = 0; k < 4; k++) begin
      ext <= 0;
      wb(1, OFS_IRQ_CONTROL, 32'h90);
      repeat (k) @(posedge clk);
      ext <= 1;
      wait_hi(vl);
      chk(n >= 13 && n <= 17, 1);
    end
    ext <= 0;
    wb(1, OFS_IRQ_CONTROL, 32'h10);
    wb(1, OFS_IRQ_CONTROL, 32'h90);
    ext <= 1;
    t0 = takes;
    // let the request reach the entry pipeline before the clear lands
    repeat (6) @(posedge clk);
    wb(1, OFS_IRQ_CONTROL, 32'h12);
    wait_hi(nop);
    chk(nop, 1);
    repeat (30) @(posedge clk);
    chk(takes, t0);
    wb(0, OFS_EVT_STATUS, '0);
    chk(rdat & 32'h4, 32'h4);
    rd_chk(OFS_IRQ_CONTROL, 32'h12);
    wb(1, OFS_IRQ_CONTROL, 32'h92);
    wait_hi(vl);
    chk(vl, 1);
    gclr <= 1;
    @(posedge clk);
    gclr <= 0;
    wait_hi(nop);
    chk(nop, 1);
    for (int s = 0; s < 3; s++) begin
      wb(1, OFS_IRQ_CONTROL, 32'h0);
      tmr <= (s == 0);
      if (s == 1) pb <= ~pb;
      if (s == 2) cmp <= ~cmp;
      @(posedge clk);
      tmr <= 0;
      repeat (6) @(posedge clk);
      rd_chk(OFS_IRQ_CONTROL, s == 0 ? 32'h4 : s == 1 ? 32'h1 : 32'h0);
    end
    rd_chk(OFS_PERIPH_FLAG, 32'h40);
    t0 = takes;
    wb(1, OFS_IRQ_CONTROL, 32'h80);
    repeat (30) @(posedge clk);
    chk(takes, t0);
    wb(1, OFS_IRQ_CONTROL, 32'hc0);
    wait_hi(vl);
    chk(vl, 1);
    wb(1, OFS_POWER_STATUS, 32'h3);
    wb(1, OFS_IRQ_CONTROL, 32'h80);
    rst_n <= 0;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rd_chk(OFS_IRQ_CONTROL, 32'h0);
    wb(0, OFS_POWER_STATUS, '0);
    chk(rdat & 32'h2, 32'h2);
    end_sim();
  end
  // watchdog: the run needs about four hundred and twenty clocks
  initial begin
    repeat (8000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
